// ===== tb/swpl_host_model.sv
// host spi master model: mode 0 frames, msb first
// assumes the bench sys_clk; sclk period is eight sys_clk cycles, 320 ns
`timescale 1ns/1ps
module swpl_host_model (
    input  wire logic sys_clk,
    output logic      cs_n,
    output logic      sclk,
    output logic      mosi
);
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        mosi = 1'b0;
    end

    // --------------------------------------------------------
    // one frame of the n low bits of d
    // --------------------------------------------------------
    task automatic frame(input logic [31:0] d, input int n);
        @(posedge sys_clk);
        #1 cs_n = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            mosi = d[i];
            repeat (4) @(posedge sys_clk);
            #1 sclk = 1'b1;
            repeat (4) @(posedge sys_clk);
            #1 sclk = 1'b0;
        end
        repeat (4) @(posedge sys_clk);
        // deselect four sys_clk cycles after the last sclk fall
        #1 cs_n = 1'b1;
        // released data line must not keep its value
        mosi = ~mosi;
        repeat (8) @(posedge sys_clk);
    endtask : frame
endmodule : swpl_host_model

// ===== tb/test_spi_flash_write_protect_latch.sv
// self-checking bench of the write-permission block
// assumes the host model drives the spi pins; status writes last 8 cycles
`timescale 1ns/1ps
module test_spi_flash_write_protect_latch;
    logic       sys_clk = 1'b0;
    logic       reset   = 1'b1;
    logic       cs_n, sclk, mosi, wp_n, array_busy;
    logic [2:0] prot_sector;
    logic       write_enable_latch, write_in_progress, hw_protected;
    logic       array_op_start, op_rejected;
    logic [7:0] status_reg_one, config_reg, array_op_code;
    logic [1:0] bank_address_reg;
    logic [7:0] last_code = 8'h00;
    logic [7:0] ops [3] = '{swpl_pkg::OP_PAGE_PROG, swpl_pkg::OP_QUAD_PROG,
                            swpl_pkg::OP_SECT_ERASE};
    int         num_errors = 0;
    int         tests_run  = 0;
    int         rej_n      = 0;
    int         start_n    = 0;
    int         cycles     = 0;

    always #20 sys_clk = ~sys_clk;

    swpl_host_model i_host (.sys_clk(sys_clk), .cs_n(cs_n), .sclk(sclk),
                            .mosi(mosi));

    swpl_latch #(.WRITE_CYCLES(8)) i_dut (
        .sys_clk(sys_clk), .reset(reset), .cs_n(cs_n), .sclk(sclk),
        .mosi(mosi), .wp_n(wp_n), .array_busy(array_busy),
        .prot_sector(prot_sector), .write_enable_latch(write_enable_latch),
        .write_in_progress(write_in_progress),
        .status_reg_one(status_reg_one), .config_reg(config_reg),
        .bank_address_reg(bank_address_reg), .hw_protected(hw_protected),
        .array_op_start(array_op_start), .array_op_code(array_op_code),
        .op_rejected(op_rejected));

    // --------------------------------------------------------
    // pulse counters and run limit
    // --------------------------------------------------------
    always @(posedge sys_clk) begin
        cycles++;
        if (op_rejected === 1'b1) rej_n++;
        if (array_op_start === 1'b1) begin
            start_n++;
            last_code = array_op_code;
        end
        if (cycles == 30000) begin
            num_errors++;
            final_report();
        end
    end

    // --------------------------------------------------------
    // tasks
    // --------------------------------------------------------
    task automatic final_report;
        $display("checks %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : final_report

    task automatic check_bit(input logic a, input logic e, input string m);
        tests_run++;
        if (a !== e) begin
            num_errors++;
            $display("CHECK FAILED at %0t: %s", $time, m);
        end
    endtask : check_bit

    task automatic check_byte(input logic [7:0] a, input logic [7:0] e,
                              input string m);
        tests_run++;
        if (a !== e) begin
            num_errors++;
            $display("CHECK FAILED at %0t: %s", $time, m);
        end
    endtask : check_byte

    task automatic send(input logic [31:0] d, input int n);
        i_host.frame(d, n);
        for (int k = 0; k < 60 && write_in_progress !== 1'b0; k++)
            @(posedge sys_clk);
        repeat (4) @(posedge sys_clk);
    endtask : send

    task automatic pins(input logic wp, input logic busy,
                        input logic [2:0] sec);
        @(posedge sys_clk);
        #1 wp_n = wp;
        array_busy = busy;
        prot_sector = sec;
        repeat (6) @(posedge sys_clk);
    endtask : pins

    // --------------------------------------------------------
    // tests
    // --------------------------------------------------------
    initial begin
        wp_n = 1'b1;
        array_busy = 1'b0;
        prot_sector = 3'h0;
        repeat (2) @(posedge sys_clk);
        #1 reset = 1'b0;
        repeat (3) @(posedge sys_clk);
        check_byte(status_reg_one, 8'h00, "status reset");
        check_byte(config_reg, 8'h00, "config reset");
        check_bit(write_enable_latch, 1'b0, "latch reset");
        $display("test reset done");

        send({swpl_pkg::OP_SET_LATCH, 1'b0}, 9);
        check_bit(write_enable_latch, 1'b0, "set with 9 bits");
        send(swpl_pkg::OP_SET_LATCH, 8);
        check_bit(write_enable_latch, 1'b1, "set latch");
        check_bit(status_reg_one[1], 1'b1, "latch in status");
        send({swpl_pkg::OP_CLR_LATCH, 1'b0}, 9);
        check_bit(write_enable_latch, 1'b1, "clear with 9 bits");
        send(swpl_pkg::OP_CLR_LATCH, 8);
        check_bit(write_enable_latch, 1'b0, "clear latch");
        i_host.frame({swpl_pkg::OP_REG_WRITE, 8'h8C}, 16);
        check_bit(write_in_progress, 1'b0, "no busy on refusal");
        send(swpl_pkg::OP_BULK_ERASE, 8);
        check_byte(status_reg_one, 8'h00, "write without latch");
        check_byte(8'(rej_n), 8'h02, "refusals without latch");
        $display("test latch done");

        pins(1'b0, 1'b0, 3'h0);
        send(swpl_pkg::OP_SET_LATCH, 8);
        send({swpl_pkg::OP_REG_WRITE, 8'h8C, 8'h00}, 24);
        check_byte(status_reg_one, 8'h8C, "soft mode write");
        check_bit(hw_protected, 1'b1, "protect after status_write_disable");
        send(swpl_pkg::OP_SET_LATCH, 8);
        i_host.frame({swpl_pkg::OP_REG_WRITE, 8'h00}, 16);
        check_bit(write_in_progress, 1'b0, "no busy on hw reject");
        send(swpl_pkg::OP_SET_LATCH, 8);
        check_byte(status_reg_one & 8'hFC, 8'h8C, "hw reject");
        check_byte(8'(rej_n), 8'h03, "hw reject pulse");
        pins(1'b1, 1'b0, 3'h0);
        check_bit(hw_protected, 1'b0, "pin high releases");
        send({swpl_pkg::OP_REG_WRITE, 8'h84, 8'h02}, 24);
        check_byte(status_reg_one, 8'h84, "write, pin high");
        check_byte(config_reg, 8'h02, "config written");
        pins(1'b0, 1'b0, 3'h0);
        check_bit(hw_protected, 1'b0, "quad disables");
        send(swpl_pkg::OP_SET_LATCH, 8);
        send({swpl_pkg::OP_REG_WRITE, 8'h84, 8'h00}, 24);
        check_byte(config_reg, 8'h00, "quad write, pin low");
        pins(1'b1, 1'b0, 3'h0);
        pins(1'b0, 1'b0, 3'h0);
        check_bit(hw_protected, 1'b1, "pin low after status_write_disable");
        pins(1'b1, 1'b0, 3'h0);
        $display("test protection done");

        for (int i = 0; i < 3; i++) begin
            pins(1'b1, 1'b0, 3'h7);
            send(swpl_pkg::OP_SET_LATCH, 8);
            i_host.frame({ops[i], 24'h000000}, 32);
            check_bit(write_in_progress, 1'b0, "blocked op");
            check_byte(8'(rej_n), 8'(4 + i), "protected range");
            pins(1'b1, 1'b0, 3'h0);
            send(swpl_pkg::OP_SET_LATCH, 8);
            send({ops[i], 24'h000000}, 32);
            check_byte(8'(start_n), 8'(1 + i), "open range");
            check_byte(last_code, ops[i], "op code");
        end
        $display("test array done");

        send(swpl_pkg::OP_BANK_ACCESS, 8);
        send({swpl_pkg::OP_REG_WRITE, 8'hFF}, 16);
        check_byte(8'(bank_address_reg), 8'h03, "bank load");
        check_byte(status_reg_one & 8'hFC, 8'h84, "status kept");
        send(swpl_pkg::OP_SET_LATCH, 8);
        pins(1'b1, 1'b1, 3'h0);
        i_host.frame(swpl_pkg::OP_CLR_LATCH, 8);
        check_bit(write_enable_latch, 1'b1, "clear while busy");
        pins(1'b1, 1'b0, 3'h0);
        send(swpl_pkg::OP_CLR_LATCH, 8);
        check_bit(write_enable_latch, 1'b0, "clear when idle");
        $display("test bank and busy done");
        final_report();
    end
endmodule : test_spi_flash_write_protect_latch

// ===== verilog/swpl_latch.sv
// write-enable latch and register write protection of a serial flash
// assumes spi mode 0; host drives cs_n, sclk, data in; 25 MHz sys_clk
`timescale 1ns/1ps
module swpl_latch #(
    parameter int WRITE_CYCLES = swpl_pkg::WRITE_CYCLES,
    parameter int BUSY_W       = 16
) (
    input  wire logic       sys_clk,
    input  wire logic       reset,
    input  wire logic       cs_n,
    input  wire logic       sclk,
    input  wire logic       mosi,
    input  wire logic       wp_n,
    input  wire logic       array_busy,
    input  wire logic [2:0] prot_sector,
    output logic            write_enable_latch,
    output logic            write_in_progress,
    output logic [7:0]      status_reg_one,
    output logic [7:0]      config_reg,
    output logic [1:0]      bank_address_reg,
    output logic            hw_protected,
    output logic            array_op_start,
    output logic [7:0]      array_op_code,
    output logic            op_rejected
);
    // ------------------------------------------------------------
    // pin synchronisation
    // ------------------------------------------------------------
    logic [3:0] pins_s;

    swpl_sync #(.W(4)) u_sync (
        .sys_clk  (sys_clk),
        .reset    (reset),
        .async_in ({cs_n, sclk, mosi, wp_n}),
        .sync_out (pins_s)
    );

    logic cs_s, sclk_s, mosi_s, wp_s;
    assign cs_s   = pins_s[3];
    assign sclk_s = pins_s[2];
    assign mosi_s = pins_s[1];
    assign wp_s   = pins_s[0];

    logic cs_prev_q, sclk_prev_q;
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            cs_prev_q   <= 1'b1;
            // matches the synchroniser's reset level, so no false edge
            sclk_prev_q <= 1'b1;
        end else begin
            cs_prev_q   <= cs_s;
            sclk_prev_q <= sclk_s;
        end
    end

    logic sclk_rise, cs_fall, cs_rise;
    assign sclk_rise = sclk_s & ~sclk_prev_q & ~cs_s;
    assign cs_fall   = ~cs_s & cs_prev_q;
    assign cs_rise   = cs_s & ~cs_prev_q;

    // ------------------------------------------------------------
    // frame shifter
    // ------------------------------------------------------------
    logic [5:0]  bit_cnt_q;
    logic [7:0]  shift_q;
    logic [7:0]  opcode_q;
    logic [7:0]  data1_q;
    logic [7:0]  data2_q;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            bit_cnt_q <= 6'h00;
            shift_q   <= 8'h00;
            opcode_q  <= 8'h00;
            data1_q   <= 8'h00;
            data2_q   <= 8'h00;
        end else if (cs_fall) begin
            bit_cnt_q <= 6'h00;
        end else if (sclk_rise) begin
            shift_q <= {shift_q[6:0], mosi_s};
            if (bit_cnt_q != 6'h3F)
                bit_cnt_q <= bit_cnt_q + 6'h01;
            if (bit_cnt_q == 6'h07)
                opcode_q <= {shift_q[6:0], mosi_s};
            if (bit_cnt_q == 6'h0F)
                data1_q <= {shift_q[6:0], mosi_s};
            if (bit_cnt_q == 6'h17)
                data2_q <= {shift_q[6:0], mosi_s};
        end
    end

    // ------------------------------------------------------------
    // protection state
    // ------------------------------------------------------------
    logic quad_on, status_write_disable, hw_prot;
    assign quad_on = config_reg[swpl_pkg::CR_QUAD_BIT];
    assign status_write_disable    = status_reg_one[swpl_pkg::SR_STATUS_WRITE_DISABLE_BIT];
    // either order of status_write_disable and pin low while quad_on is clear; leaves on pin high, quad_on set or status_write_disable clear
    assign hw_prot = status_write_disable & ~wp_s & ~quad_on;
    assign hw_protected = hw_prot;

    // decoded at the closing chip-select edge
    logic ends8, ends16, ends24, ends40;
    assign ends8  = cs_rise && bit_cnt_q == 6'd8;
    assign ends16 = cs_rise && bit_cnt_q == 6'd16;
    assign ends24 = cs_rise && bit_cnt_q == 6'd24;
    assign ends40 = cs_rise && bit_cnt_q >= 6'd40;

    function automatic logic is_array_op(input logic [7:0] op);
        return op == swpl_pkg::OP_PAGE_PROG || op == swpl_pkg::OP_QUAD_PROG
            || op == swpl_pkg::OP_SECT_ERASE || op == swpl_pkg::OP_BULK_ERASE
            || op == swpl_pkg::OP_OTP_PROG;
    endfunction : is_array_op

    // ------------------------------------------------------------
    // bank access arming
    // ------------------------------------------------------------
    logic bank_armed_q;
    always_ff @(posedge sys_clk) begin
        if (reset)
            bank_armed_q <= 1'b0;
        else if (cs_rise)
            bank_armed_q <= ends8 && opcode_q == swpl_pkg::OP_BANK_ACCESS
                            && !write_in_progress;
    end

    logic bank_load, wr_frame, wr_ok, wr_go;
    assign bank_load = bank_armed_q && opcode_q == swpl_pkg::OP_REG_WRITE
                       && (ends16 || ends24);
    assign wr_frame  = !bank_armed_q && opcode_q == swpl_pkg::OP_REG_WRITE
                       && (ends16 || (ends24 && !quad_on))
                       || (!bank_armed_q && ends24 && quad_on
                           && opcode_q == swpl_pkg::OP_REG_WRITE);
    // status_write_disable=0 ignores pin; status_write_disable=1 needs pin high or quad_on set, sampled now
    assign wr_ok = write_enable_latch && !hw_prot
                   && !write_in_progress;
    assign wr_go = wr_frame && wr_ok;

    // ------------------------------------------------------------
    // array program and erase gate
    // ------------------------------------------------------------
    logic [2:0] bp;
    logic       in_range, arr_frame, arr_ok;
    assign bp        = status_reg_one[swpl_pkg::SR_BP_LSB +: 3];
    assign in_range  = bp != 3'h0 && (opcode_q == swpl_pkg::OP_BULK_ERASE
                       || prot_sector >= ~bp + 3'h1);
    assign arr_frame = is_array_op(opcode_q)
                       && (opcode_q == swpl_pkg::OP_BULK_ERASE ? ends8 : ends40
                           || (ends24 && 1'b0) || (cs_rise
                           && bit_cnt_q >= 6'd32));
    assign arr_ok    = write_enable_latch && !in_range
                       && !write_in_progress;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            array_op_start <= 1'b0;
            array_op_code  <= 8'h00;
            op_rejected    <= 1'b0;
        end else begin
            array_op_start <= arr_frame && arr_ok;
            if (arr_frame && arr_ok)
                array_op_code <= opcode_q;
            op_rejected <= (arr_frame && !arr_ok)
                           || (wr_frame && !wr_ok);
        end
    end

    // ------------------------------------------------------------
    // self-timed register write
    // ------------------------------------------------------------
    logic [BUSY_W-1:0] busy_cnt_q;
    logic              reg_busy_q;
    logic              pend16_q;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            busy_cnt_q <= '0;
            reg_busy_q <= 1'b0;
            pend16_q   <= 1'b0;
        end else if (wr_go) begin
            busy_cnt_q <= BUSY_W'(WRITE_CYCLES - 1);
            reg_busy_q <= 1'b1;
            pend16_q   <= ends24;
        end else if (reg_busy_q && busy_cnt_q == '0) begin
            reg_busy_q <= 1'b0;
        end else if (reg_busy_q) begin
            busy_cnt_q <= busy_cnt_q - 1'b1;
        end
    end

    logic reg_done;
    assign reg_done = reg_busy_q && busy_cnt_q == '0;
    assign write_in_progress = reg_busy_q | array_busy;

    // ------------------------------------------------------------
    // status, configuration and bank registers
    // ------------------------------------------------------------
    logic [5:0] sr_hi_q;
    logic       sr_wip_q;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            sr_hi_q    <= swpl_pkg::SR_RESET[7:2];
            sr_wip_q   <= 1'b0;
            config_reg <= swpl_pkg::CR_RESET;
        end else begin
            sr_wip_q <= write_in_progress;
            // bp bits only change through an accepted write
            if (reg_done) begin
                sr_hi_q <= data1_q[7:2];
                if (pend16_q)
                    config_reg <= data2_q;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset)
            bank_address_reg <= swpl_pkg::BANK_RESET;
        else if (bank_load)
            bank_address_reg <= data1_q[1:0];
    end

    // ------------------------------------------------------------
    // write enable latch
    // ------------------------------------------------------------
    logic set_hit, clr_hit;
    assign set_hit = ends8 && opcode_q == swpl_pkg::OP_SET_LATCH;
    assign clr_hit = ends8 && opcode_q == swpl_pkg::OP_CLR_LATCH
                     && !write_in_progress;

    always_ff @(posedge sys_clk) begin
        if (reset)
            write_enable_latch <= 1'b0;
        else if (set_hit)
            write_enable_latch <= 1'b1;
        else if (clr_hit || reg_done || (arr_frame && arr_ok))
            write_enable_latch <= 1'b0;
    end

    assign status_reg_one = {sr_hi_q, write_enable_latch, sr_wip_q};

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_hw_reject: assert property (@(posedge sys_clk) disable iff (reset)
        wr_frame && hw_prot |=> !reg_busy_q && $stable(status_reg_one[7:2]))
        else $error("register write ran under hardware protection");
    a_sw_accept: assert property (@(posedge sys_clk) disable iff (reset)
        wr_frame && write_enable_latch && !status_write_disable && !write_in_progress
        |=> reg_busy_q)
        else $error("software mode write not started");
    a_pin_accept: assert property (@(posedge sys_clk) disable iff (reset)
        wr_frame && wr_ok && status_write_disable |=> reg_busy_q)
        else $error("pin-high write not started");
    a_latch_set: assert property (@(posedge sys_clk) disable iff (reset)
        set_hit |=> write_enable_latch)
        else $error("latch not set");
    a_latch_wip: assert property (@(posedge sys_clk) disable iff (reset)
        ends8 && opcode_q == swpl_pkg::OP_CLR_LATCH && write_in_progress
        && write_enable_latch |=> write_enable_latch)
        else $error("clear honoured while busy");
    a_no_latch: assert property (@(posedge sys_clk) disable iff (reset)
        arr_frame && !write_enable_latch |=> !array_op_start && op_rejected)
        else $error("array op ran without latch");
    a_bank_load: assert property (@(posedge sys_clk) disable iff (reset)
        bank_load |=> bank_address_reg == $past(data1_q[1:0]) && !reg_busy_q)
        else $error("bank load wrong");
    a_reset_zero: assert property (@(posedge sys_clk)
        reset |=> status_reg_one[7:2] == 6'h00)
        else $error("status not cleared");

endmodule : swpl_latch

// ===== verilog/swpl_pkg.sv
// constants of the flash write-permission block
// assumes one 25 MHz system clock; spi pins are sampled, not clocked on
package swpl_pkg;

    // ------------------------------------------------------------
    // opcodes
    // ------------------------------------------------------------
    localparam logic [7:0] OP_SET_LATCH   = 8'h06;
    localparam logic [7:0] OP_CLR_LATCH   = 8'h04;
    localparam logic [7:0] OP_REG_WRITE   = 8'h01;
    localparam logic [7:0] OP_BANK_ACCESS = 8'hB9;
    localparam logic [7:0] OP_PAGE_PROG   = 8'h02;
    localparam logic [7:0] OP_QUAD_PROG   = 8'h32;
    localparam logic [7:0] OP_SECT_ERASE  = 8'hD8;
    localparam logic [7:0] OP_BULK_ERASE  = 8'hC7;
    localparam logic [7:0] OP_OTP_PROG    = 8'h42;

    // ------------------------------------------------------------
    // status and configuration fields
    // ------------------------------------------------------------
    localparam int         SR_LATCH_BIT = 1;
    localparam int         SR_BP_LSB    = 2;
    localparam int         SR_STATUS_WRITE_DISABLE_BIT  = 7;
    localparam int         CR_QUAD_BIT  = 1;
    localparam logic [7:0] SR_RESET     = 8'h00;
    localparam logic [7:0] CR_RESET     = 8'h00;
    localparam logic [1:0] BANK_RESET   = 2'h0;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int SYS_CLK_MHZ  = 25;
    localparam int WRITE_TIME_US = 200;
    localparam int WRITE_CYCLES  = WRITE_TIME_US * SYS_CLK_MHZ;

endpackage : swpl_pkg

// ===== verilog/swpl_sync.sv
// two-flop synchroniser bank for the spi pins
// assumes inputs asynchronous to sys_clk
`timescale 1ns/1ps
module swpl_sync #(
    parameter int W = 4
) (
    input  wire logic         sys_clk,
    input  wire logic         reset,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_q;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            meta_q   <= '1;
            sync_out <= '1;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule : swpl_sync
